// ### hdl/crb_pkg.sv
package crb_pkg;

  // ****************************************************
  // Register map (word index on the plain register port)
  // ****************************************************
  localparam int CRB_ADDR_W = 4;
  localparam logic [3:0] CRB_OFF_DEST_PTR = 4'h0;
  localparam logic [3:0] CRB_OFF_OVF_LOW = 4'h1;
  localparam logic [3:0] CRB_OFF_OVF_HIGH = 4'h2;
  localparam logic [3:0] CRB_OFF_IRQ_STAT = 4'h3;
  localparam logic [3:0] CRB_OFF_IRQ_MASK = 4'h4;
  localparam logic [3:0] CRB_OFF_ROUTE_STAT = 4'h5;

  // ****************************************************
  // Field layout and reset values
  // ****************************************************
  localparam int CRB_F15_LSB = 12;
  localparam int CRB_F14_LSB = 8;
  localparam int CRB_F13_LSB = 4;
  localparam int CRB_F12_LSB = 0;
  localparam logic [3:0] CRB_PTR_FIFO = 4'hf;
  localparam logic [15:0] CRB_DEST_PTR_RST = 16'h0000;
  localparam logic [15:0] CRB_OVF_RST = 16'h0000;
  localparam logic [15:0] CRB_IRQ_RST = 16'h0000;
  localparam int CRB_NUM_BUF = 32;

  // Interrupt status bits
  localparam int CRB_IRQ_OVF_LOW = 0;
  localparam int CRB_IRQ_OVF_HIGH = 1;
  localparam int CRB_IRQ_FIFO_HIT = 2;
  localparam int CRB_IRQ_BUF_HIT = 3;

  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [15:0] wdata;
  } crb_req_t;

  // Routing decision for one filter hit
  typedef struct packed {
    logic valid;
    logic to_fifo;
    logic [3:0] buf_idx;
  } crb_route_t;

endpackage

// ### hdl/crb_ptr_decode.sv
`timescale 1ns/10ps
`default_nettype none

// Turns one filter hit and the pointer word into a destination
module crb_ptr_decode (
  // Hit from the filter matcher
  input wire logic hit_valid,
  input wire logic [1:0] hit_sel,
  // Pointer register contents
  input wire logic [15:0] dest_ptr,
  // Decoded destination
  output var crb_pkg::crb_route_t route
);
  import crb_pkg::*;

  // Pick the 4-bit field of the hitting filter
  function automatic logic [3:0] field_of(input logic [15:0] p, input logic [1:0] s);
    case (s)
      2'h3: field_of = p[CRB_F15_LSB +: 4];
      2'h2: field_of = p[CRB_F14_LSB +: 4];
      2'h1: field_of = p[CRB_F13_LSB +: 4];
      default: field_of = p[CRB_F12_LSB +: 4];
    endcase
  endfunction

  wire logic [3:0] code;
  assign code = field_of(dest_ptr, hit_sel);
  assign route.valid = hit_valid;
  assign route.to_fifo = (code == CRB_PTR_FIFO);
  assign route.buf_idx = code;

endmodule // crb_ptr_decode
`default_nettype wire

// ### hdl/crb_rx_route.sv
`timescale 1ns/10ps
`default_nettype none

module crb_rx_route (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clk_en,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Filter hit from the matcher (sel 3..0 = filter 15..12)
  input wire logic hit_valid,
  input wire logic [1:0] hit_sel,
  // Buffer full flags from message storage
  input wire logic [31:0] buf_full,
  // Storage command
  output logic store_valid,
  output logic store_to_fifo,
  output logic [4:0] store_buf,
  // Interrupt
  output logic irq
);
  import crb_pkg::*;

  // ****************************************************
  // Register port decode
  // ****************************************************
  crb_req_t req;
  assign req.wr = reg_wr;
  assign req.rd = reg_rd;
  assign req.addr = reg_addr;
  assign req.wdata = reg_wdata;

  wire logic wr_ptr = clk_en && req.wr && (req.addr == CRB_OFF_DEST_PTR);
  wire logic wr_ovl = clk_en && req.wr && (req.addr == CRB_OFF_OVF_LOW);
  wire logic wr_ovh = clk_en && req.wr && (req.addr == CRB_OFF_OVF_HIGH);
  wire logic wr_msk = clk_en && req.wr && (req.addr == CRB_OFF_IRQ_MASK);
  wire logic rd_stat = clk_en && req.rd && (req.addr == CRB_OFF_IRQ_STAT);

  // ****************************************************
  // State
  // ****************************************************
  logic [15:0] dest_ptr_r;
  logic [31:0] ovf_r, ovf_nxt;
  logic [15:0] stat_r, stat_nxt, mask_r;
  logic [15:0] rdata_nxt;
  logic [5:0] last_route_r;
  crb_route_t route;

  crb_ptr_decode u_dec (
    .hit_valid(hit_valid),
    .hit_sel(hit_sel),
    .dest_ptr(dest_ptr_r),
    .route(route)
  );

  // Limitation: pointer codes reach buffers 1 to 14 only, so flags 15 to 31
  // are reachable by software reads and clears but never set from a hit here.
  // The upper status bit therefore stays quiet in this block.
  // Code 0000 has no destination in the encoding, so such a hit is dropped
  wire logic route_ok = route.valid && (route.to_fifo || route.buf_idx != 4'h0);
  wire logic to_buf = route_ok && !route.to_fifo;
  wire logic [4:0] buf5 = {1'b0, route.buf_idx};
  wire logic ovf_hit = to_buf && buf_full[buf5];
  wire logic [31:0] ovf_set = ovf_hit ? (32'h0000_0001 << buf5) : 32'h0000_0000;

  // Write-zero-to-clear masks; non-addressed half keeps all ones
  // zero clears only
  wire logic [31:0] ovf_keep = {wr_ovh ? req.wdata : 16'hffff, wr_ovl ? req.wdata : 16'hffff};
  assign ovf_nxt = (ovf_r & ovf_keep) | ovf_set;

  // Sticky events; a read of the status register clears, a new event still wins
  wire logic [15:0] ev;
  assign ev = {12'h000, to_buf && !ovf_hit, route_ok && route.to_fifo,
               ovf_hit && buf5[4], ovf_hit && !buf5[4]};
  assign stat_nxt = (rd_stat ? 16'h0000 : stat_r) | (clk_en ? ev : 16'h0000);

  // Read mux; unmapped addresses return zero
  // low and high halves
  always_comb begin
    case (req.addr)
      CRB_OFF_DEST_PTR: rdata_nxt = dest_ptr_r;
      CRB_OFF_OVF_LOW: rdata_nxt = ovf_r[15:0];
      CRB_OFF_OVF_HIGH: rdata_nxt = ovf_r[31:16];
      CRB_OFF_IRQ_STAT: rdata_nxt = stat_r;
      CRB_OFF_IRQ_MASK: rdata_nxt = mask_r;
      CRB_OFF_ROUTE_STAT: rdata_nxt = {10'h000, last_route_r};
      default: rdata_nxt = 16'h0000;
    endcase
  end

  // Registers
  // zero reset
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      dest_ptr_r <= CRB_DEST_PTR_RST;
      ovf_r <= {CRB_OVF_RST, CRB_OVF_RST};
      stat_r <= CRB_IRQ_RST;
      mask_r <= CRB_IRQ_RST;
      last_route_r <= 6'h00;
      reg_rdata <= 16'h0000;
      store_valid <= 1'b0;
      store_to_fifo <= 1'b0;
      store_buf <= 5'h00;
      irq <= 1'b0;
    end else if (clk_en) begin
      if (wr_ptr) begin
        dest_ptr_r <= req.wdata;
      end
      if (wr_msk) begin
        mask_r <= req.wdata;
      end
      ovf_r <= ovf_nxt;
      stat_r <= stat_nxt;
      reg_rdata <= req.rd ? rdata_nxt : 16'h0000;
      store_valid <= route_ok && !ovf_hit;
      store_to_fifo <= route_ok && route.to_fifo;
      store_buf <= route_ok ? buf5 : 5'h00;
      if (route_ok) begin
        last_route_r <= {1'b1, route.to_fifo, route.buf_idx};
      end
      irq <= |(stat_nxt & mask_r);
    end
  end

  // ****************************************************
  // Checks
  // ****************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  chk_ovf_set_full: assert property (clk_en && ovf_hit |=> ovf_r[$past(buf5)])
    else $error("overflow flag not set");
  chk_fifo_route: assert property (clk_en && route.valid && route.to_fifo |=> store_valid && store_to_fifo)
    else $error("fifo code not routed to fifo");
  chk_buf_route: assert property (clk_en && to_buf && !buf_full[buf5] |=> store_valid && store_buf == $past(buf5))
    else $error("buffer route wrong");
  chk_low_read: assert property (clk_en && req.rd && req.addr == CRB_OFF_OVF_LOW |=> reg_rdata == $past(ovf_r[15:0]))
    else $error("low overflow readback wrong");
  chk_high_read: assert property (clk_en && req.rd && req.addr == CRB_OFF_OVF_HIGH |=> reg_rdata == $past(ovf_r[31:16]))
    else $error("high overflow readback wrong");
  chk_one_keeps: assert property (clk_en && wr_ovl && !ovf_hit |=> ovf_r[15:0] == ($past(ovf_r[15:0]) & $past(req.wdata)))
    else $error("write-zero-clear wrong");
  chk_no_sw_set: assert property (clk_en && !ovf_hit |=> (ovf_r & ~$past(ovf_r)) == 32'h0000_0000)
    else $error("flag set without overflow");
  chk_set_wins: assert property (clk_en && ovf_hit && (wr_ovl || wr_ovh) |=> ovf_r[$past(buf5)])
    else $error("clear beat a set");
  chk_irq_level: assert property (clk_en && |(stat_nxt & mask_r) |=> irq)
    else $error("irq missing");

  // ****************************************************
  // Reset and enable checks
  // ****************************************************
  // Outputs must leave reset at zero, so no stray store leaks to storage
  // zero outputs
  chk_reset_outs: assert property ($past(srst) |-> reg_rdata == 16'h0000 && !store_valid && !irq)
    else $error("outputs not zero after reset");

  // Registers must hold their documented reset values
  // zero registers
  chk_reset_regs: assert property ($past(srst) |-> dest_ptr_r == CRB_DEST_PTR_RST && mask_r == CRB_IRQ_RST
    && ovf_r == {CRB_OVF_RST, CRB_OVF_RST})
    else $error("registers not at reset value");

  // Enable low freezes everything, read data included
  chk_enable_freeze: assert property (!clk_en |=> ovf_r == $past(ovf_r) && stat_r == $past(stat_r)
    && reg_rdata == $past(reg_rdata))
    else $error("state moved while enable low");

  // ****************************************************
  // Register port checks
  // ****************************************************
  // pointer write lands
  // A write takes effect on the very next cycle
  chk_ptr_write: assert property (wr_ptr |=> dest_ptr_r == $past(req.wdata))
    else $error("pointer write lost");

  // pointer holds
  // Without a write the routing must never drift
  chk_ptr_hold: assert property (!wr_ptr |=> dest_ptr_r == $past(dest_ptr_r))
    else $error("pointer changed without write");

  // Mask follows the written word
  // A stale mask would hide or invent interrupts
  chk_mask_write: assert property (wr_msk |=> mask_r == $past(req.wdata))
    else $error("mask write lost");

  // pointer readback
  // Software must see what it wrote
  chk_ptr_read: assert property (clk_en && req.rd && req.addr == CRB_OFF_DEST_PTR |=> reg_rdata == $past(dest_ptr_r))
    else $error("pointer readback wrong");

  // Read data stands until the next enabled cycle with no read, then returns to zero
  // Zero when idle lets a shared read bus OR several slaves together
  chk_rdata_idle: assert property (clk_en && !req.rd |=> reg_rdata == 16'h0000)
    else $error("read data not zero when idle");

  // ****************************************************
  // Routing checks
  // ****************************************************
  // filter 15 field
  // Each select must pick exactly its own nibble
  chk_f15_field: assert property (hit_sel == 2'h3 |-> route.buf_idx == dest_ptr_r[CRB_F15_LSB +: 4])
    else $error("filter 15 field wrong");

  chk_f14_field: assert property (hit_sel == 2'h2 |-> route.buf_idx == dest_ptr_r[CRB_F14_LSB +: 4])
    else $error("filter 14 field wrong");

  chk_f13_field: assert property (hit_sel == 2'h1 |-> route.buf_idx == dest_ptr_r[CRB_F13_LSB +: 4])
    else $error("filter 13 field wrong");

  chk_f12_field: assert property (hit_sel == 2'h0 |-> route.buf_idx == dest_ptr_r[CRB_F12_LSB +: 4])
    else $error("filter 12 field wrong");

  // code zero dropped
  // Code 0000 names no destination, so storing it would corrupt a buffer
  chk_zero_drop: assert property (clk_en && route.valid && route.buf_idx == 4'h0 |=> !store_valid && !store_to_fifo)
    else $error("code zero was routed");

  // full buffer not stored
  // Overwriting a full buffer would lose the unread message
  chk_full_nostore: assert property (clk_en && ovf_hit |=> !store_valid)
    else $error("store issued to full buffer");

  chk_fifo_valid: assert property (store_to_fifo |-> store_valid)
    else $error("fifo route without store");

  // buffer range
  // Buffer codes only span 1 to 14
  chk_buf_range: assert property (store_valid && !store_to_fifo |-> store_buf != 5'h00 && store_buf <= 5'h0e)
    else $error("buffer index out of range");

  // ****************************************************
  // Overflow and status checks
  // ****************************************************
  // high zero clears
  // Same write-zero rule on the upper word
  chk_high_write: assert property (clk_en && wr_ovh && !ovf_hit
    |=> ovf_r[31:16] == ($past(ovf_r[31:16]) & $past(req.wdata)))
    else $error("high write-zero-clear wrong");

  // halves independent
  // A write to the upper word must not touch the lower one
  chk_low_untouched: assert property (clk_en && wr_ovh && !ovf_hit |=> ovf_r[15:0] == $past(ovf_r[15:0]))
    else $error("high write disturbed low flags");

  chk_low_event: assert property (clk_en && ovf_hit && !buf5[4] |=> stat_r[CRB_IRQ_OVF_LOW])
    else $error("low overflow event missing");

  // FIFO hit event becomes sticky
  chk_fifo_event: assert property (clk_en && route_ok && route.to_fifo |=> stat_r[CRB_IRQ_FIFO_HIT])
    else $error("fifo event missing");

  // Buffer store event becomes sticky
  chk_buf_event: assert property (clk_en && to_buf && !ovf_hit |=> stat_r[CRB_IRQ_BUF_HIT])
    else $error("buffer event missing");

  // A read with no new event empties the status
  chk_stat_clear: assert property (rd_stat && ev == 16'h0000 |=> stat_r == 16'h0000)
    else $error("status not cleared by read");

  // A new event must survive a same-cycle read clear
  // Losing it would drop an interrupt that software never saw
  chk_stat_wins: assert property (rd_stat && ev != 16'h0000 |=> (stat_r & $past(ev)) == $past(ev))
    else $error("event lost to read clear");

  // Interrupt drops once nothing unmasked is pending
  chk_irq_quiet: assert property (clk_en && (stat_nxt & mask_r) == 16'h0000 |=> !irq)
    else $error("irq stuck high");

  // ****************************************************
  // Coverage of the main scenarios
  // ****************************************************
  cov_fifo: cover property (clk_en && route_ok && route.to_fifo);
  cov_overflow: cover property (clk_en && ovf_hit);
  cov_clear: cover property (clk_en && wr_ovl && |ovf_r[15:0]);
  cov_irq: cover property (irq);
  cov_set_clear: cover property (clk_en && ovf_hit && wr_ovl);

endmodule // crb_rx_route
`default_nettype wire

// ### tb/crb_rx_route_tb.sv
`timescale 1ns/10ps
`default_nettype none

module crb_rx_route_tb;
  import crb_pkg::*;
  logic sys_clk, srst, clk_en, reg_wr, reg_rd, hit_valid, store_valid, store_to_fifo, irq;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, ptr_m, st_m, mask_m;
  logic [1:0] hit_sel;
  logic [31:0] buf_full, ovf_m;
  logic [4:0] store_buf;
  int err_total, total_checks;

  crb_rx_route i_dut (.sys_clk(sys_clk), .srst(srst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .hit_valid(hit_valid), .hit_sel(hit_sel), .buf_full(buf_full), .store_valid(store_valid),
    .store_to_fifo(store_to_fifo), .store_buf(store_buf), .irq(irq));

  // ****************************************************
  // Clock, checks and verdict
  // ****************************************************
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic cmp_reg(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_reg({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic summarize;
    if (err_total == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Register contents the software should see
  function automatic logic [15:0] mdl(input logic [3:0] a);
    case (a)
      CRB_OFF_DEST_PTR: return ptr_m;
      CRB_OFF_OVF_LOW: return ovf_m[15:0];
      CRB_OFF_OVF_HIGH: return ovf_m[31:16];
      CRB_OFF_IRQ_STAT: return st_m;
      CRB_OFF_IRQ_MASK: return mask_m;
      default: return 16'h0000;
    endcase
  endfunction

  // ****************************************************
  // Bus and hit drivers
  // ****************************************************
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(negedge sys_clk);
    if (a == CRB_OFF_DEST_PTR) ptr_m = d;
    if (a == CRB_OFF_OVF_LOW) ovf_m[15:0] &= d;
    if (a == CRB_OFF_OVF_HIGH) ovf_m[31:16] &= d;
    if (a == CRB_OFF_IRQ_MASK) mask_m = d;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    cmp_reg(reg_rdata, mdl(a));
    if (a == CRB_OFF_IRQ_STAT) st_m = 16'h0000;
  endtask

  task automatic hit(input logic [1:0] s, input logic [31:0] f);
    logic [3:0] c;
    c = ptr_m[s*4 +: 4];
    @(posedge sys_clk);
    hit_valid <= 1'b1;
    hit_sel <= s;
    buf_full <= f;
    @(posedge sys_clk);
    hit_valid <= 1'b0;
    @(negedge sys_clk);
    cmp_bit(store_valid, c != 4'h0 && (c == CRB_PTR_FIFO || !f[c]));
    if (c != 4'h0) cmp_bit(store_to_fifo, c == CRB_PTR_FIFO);
    if (c != 4'h0 && c != CRB_PTR_FIFO && !f[c]) cmp_reg({11'h000, store_buf}, {12'h000, c});
    if (c == CRB_PTR_FIFO) st_m[CRB_IRQ_FIFO_HIT] = 1'b1;
    else if (c != 4'h0 && f[c]) begin
      ovf_m[c] = 1'b1;
      st_m[CRB_IRQ_OVF_LOW] = 1'b1;
    end else if (c != 4'h0) st_m[CRB_IRQ_BUF_HIT] = 1'b1;
  endtask

  task automatic chk_irq;
    @(posedge sys_clk);
    @(negedge sys_clk);
    cmp_bit(irq, |(st_m & mask_m));
  endtask

  // ****************************************************
  // Main sequence and watchdog
  // ****************************************************
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    summarize();
  end

  initial begin
    logic [3:0] a;
    {clk_en, srst} = 2'b11;
    {reg_wr, reg_rd, hit_valid, hit_sel, reg_addr, reg_wdata, buf_full} = '0;
    {ptr_m, st_m, mask_m, ovf_m} = '0;
    err_total = 0;
    total_checks = 0;
    void'($urandom(32'h3737));
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    for (int i = 0; i < 16; i++) if (i != 5) rd(i[3:0]);
    // Every pointer code on two filters each: filter i[1:0] with free buffers, filter ~i[1:0] with full buffers
    for (int i = 0; i < 16; i++) begin
      wr(CRB_OFF_DEST_PTR, {4{i[3:0]}});
      hit(i[1:0], 32'h00000000);
      hit(~i[1:0], 32'hffffffff);
    end
    wr(CRB_OFF_IRQ_MASK, 16'h0001);
    chk_irq();
    for (int n = 0; n < 400; n++) begin
      a = 4'($urandom % 16);
      case ($urandom % 6)
        0: wr(CRB_OFF_DEST_PTR, 16'($urandom));
        1: hit(2'($urandom), $urandom);
        2: wr(4'(1 + $urandom % 2), 16'($urandom));
        3: wr(CRB_OFF_IRQ_MASK, 16'($urandom % 16));
        4: rd(a == CRB_OFF_ROUTE_STAT ? CRB_OFF_IRQ_STAT : a);
        default: wr(4'(8 + $urandom % 8), 16'($urandom));
      endcase
      chk_irq();
    end
    // same-cycle set and clear, the set must win
    wr(CRB_OFF_DEST_PTR, 16'h3000);
    @(posedge sys_clk);
    hit_valid <= 1'b1;
    hit_sel <= 2'h3;
    buf_full <= 32'h0000_0008;
    reg_wr <= 1'b1;
    reg_addr <= CRB_OFF_OVF_LOW;
    reg_wdata <= 16'h0000;
    @(posedge sys_clk);
    hit_valid <= 1'b0;
    reg_wr <= 1'b0;
    @(negedge sys_clk);
    cmp_bit(store_valid, 1'b0);
    ovf_m[15:0] = 16'h0008;
    st_m[CRB_IRQ_OVF_LOW] = 1'b1;
    rd(CRB_OFF_OVF_LOW);
    // Enable low: a write must leave the pointer alone
    @(posedge sys_clk);
    clk_en <= 1'b0;
    reg_wr <= 1'b1;
    reg_addr <= CRB_OFF_DEST_PTR;
    reg_wdata <= 16'h5a5a;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    clk_en <= 1'b1;
    rd(CRB_OFF_DEST_PTR);
    summarize();
  end
endmodule // crb_rx_route_tb

`default_nettype wire
